// ===== shared/qrxo_defs.vh
// Purpose: Shared constants for the quad receive output interface.
// Assumes: Included by the design files by bare name.
// Notes:   Definitions only.
`ifndef QRXO_DEFS_VH
`define QRXO_DEFS_VH

// ==========================================================
// Structure
`define QRXO_NUM_CHAN 4
`define QRXO_SYNC_STAGES 2

// ==========================================================
// Mark polarity codes for the bipolar violation tracker
`define QRXO_POL_POS 1'b0
`define QRXO_POL_NEG 1'b1

// ==========================================================
// Reset values
`define QRXO_RST_BIT 1'b0
`define QRXO_RST_NIB 4'h0

`endif

// ===== verilog/qrxo_sync.v
// Purpose: Multi-bit two flip-flop level synchroniser into clk_i.
// Assumes: Each bit is an independent level; no bus coherence is implied.
// Notes:   Only the second stage is visible outside this module.
`timescale 1ns/1ps
`include "qrxo_defs.vh"

module qrxo_sync #(
    parameter WIDTH = 1
) (
    input wire clk_i,              // System clock
    input wire sys_rst_i,          // Synchronous reset, active high
    input wire [WIDTH-1:0] d_i,    // Asynchronous inputs
    output wire [WIDTH-1:0] q_o    // Synchronised outputs
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // ==========================================================
    // Two stage capture
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule

// ===== verilog/qrxo_top.v
// Purpose: Receive output interface for four line receiver channels towards a framer.
// Assumes: Recovered clock, rail pulses and loss detect arrive asynchronously to clk_i
//          and are slow against it (recovered clock near 8 MHz or less, clk_i 200 MHz).
//          Rail pulses and loss detect hold steady for three or more clk_i cycles around each rise.
//          Each recovered clock level lasts four or more clk_i cycles, or edges may be missed.
// Notes:   Rail and loss outputs move only on a detected rising edge of their recovered clock; the clock output follows both edges.
//          Latency from a recovered clock pin rise to the outputs is three clk_i cycles.
//          A loss pulse that begins and ends between two rises is not reported.
//          If the recovered clock stops, every output holds its last value.
//          Mute overrides both modes, the violation flag included.
//
// Functional notes
// - Loss output goes high for at least one recovered clock period.
// - Loss output stays high while loss persists, drops when it ends.
// - Single-rail: negative pin pulses one period per code violation.
// - Dual-rail: negative pulse data appears on the negative rail output.
// - Dual-rail: positive pulse data appears on the positive rail output.
// - Single-rail: decoded NRZ data appears on the positive rail output.
// - Each channel outputs its recovered clock; its outputs are referenced to it.
// - Four independent channels 0 to 3, each with own four outputs.
// - Mute enabled forces rail outputs low during loss; default disabled.
`timescale 1ns/1ps
`include "qrxo_defs.vh"

module qrxo_top #(
    parameter NUM_CHAN = `QRXO_NUM_CHAN
) (
    input wire clk_i,                          // System clock, 200 MHz
    input wire sys_rst_i,                      // Synchronous reset, active high
    input wire [NUM_CHAN-1:0] rx_rclk_i,       // Recovered clock per channel
    input wire [NUM_CHAN-1:0] rx_line_plus_in, // Positive pulse from line slicer
    input wire [NUM_CHAN-1:0] rx_line_minus_in,// Negative pulse from line slicer
    input wire [NUM_CHAN-1:0] rx_loss_det_i,   // Loss of signal from detector
    input wire [NUM_CHAN-1:0] single_rail_i,   // 1 = single-rail NRZ mode
    input wire rx_mute_on_loss_enable,         // 1 = mute rails during loss
    output wire [NUM_CHAN-1:0] rx_clk_o,       // Recovered clock out
    output wire [NUM_CHAN-1:0] rx_pos_rail_out,// Positive rail or NRZ data
    output wire [NUM_CHAN-1:0] rx_neg_rail_out,// Negative rail or code violation flag
    output wire [NUM_CHAN-1:0] rx_loss_flag    // Loss of signal indication
);

    // One synchroniser bit per channel and input group, plus the shared mute bit
    localparam SYNC_W = 5 * NUM_CHAN + 1;

    // ==========================================================
    // Input synchronisation
    wire [SYNC_W-1:0] sync_in;
    wire [SYNC_W-1:0] sync_out;
    wire [NUM_CHAN-1:0] rclk_s;
    wire [NUM_CHAN-1:0] plus_s;
    wire [NUM_CHAN-1:0] minus_s;
    wire [NUM_CHAN-1:0] loss_s;
    wire [NUM_CHAN-1:0] single_s;
    wire mute_s;

    // Mode and mute straps are synchronised too, so they may change in operation
    assign sync_in = {rx_mute_on_loss_enable,
                      single_rail_i,
                      rx_loss_det_i,
                      rx_line_minus_in,
                      rx_line_plus_in,
                      rx_rclk_i};

    qrxo_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i(sync_in),
        .q_o(sync_out)
    );

    assign rclk_s = sync_out[NUM_CHAN-1:0];
    assign plus_s = sync_out[2*NUM_CHAN-1:NUM_CHAN];
    assign minus_s = sync_out[3*NUM_CHAN-1:2*NUM_CHAN];
    assign loss_s = sync_out[4*NUM_CHAN-1:3*NUM_CHAN];
    assign single_s = sync_out[5*NUM_CHAN-1:4*NUM_CHAN];
    assign mute_s = sync_out[SYNC_W-1];

    // ==========================================================
    // Per channel output logic
    // four independent channels
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHAN; ch = ch + 1) begin : g_chan
            reg rclk_prev_q;
            reg clk_out_q;
            reg pos_q;
            reg pos_d;
            reg neg_q;
            reg neg_d;
            reg loss_q;
            reg have_mark_q;
            reg have_mark_d;
            reg last_pol_q;
            reg last_pol_d;
            reg viol;
            reg mute;
            wire rise;
            wire plus_bit;
            wire minus_bit;
            wire loss_bit;
            wire both_marks;
            wire pos_mark;
            wire neg_mark;
            wire nrz_bit;

            // ==========================================================
            // Per channel view of the synchronised inputs
            assign plus_bit = plus_s[ch];
            assign minus_bit = minus_s[ch];
            assign loss_bit = loss_s[ch];
            assign both_marks = plus_bit & minus_bit;
            assign pos_mark = plus_bit & ~minus_bit;
            assign neg_mark = minus_bit & ~plus_bit;
            // Any mark is a one in NRZ form
            assign nrz_bit = plus_bit | minus_bit;

            // ==========================================================
            // Recovered clock edge detect and forwarding
            // The forwarded clock and the data launch share one synchronised sample
            // single launch edge
            assign rise = rclk_s[ch] & ~rclk_prev_q;

            always @(posedge clk_i) begin
                if (sys_rst_i) begin
                    rclk_prev_q <= `QRXO_RST_BIT;
                    clk_out_q <= `QRXO_RST_BIT;
                end else begin
                    rclk_prev_q <= rclk_s[ch];
                    clk_out_q <= rclk_s[ch];
                end
            end

            // ==========================================================
            // Bipolar violation tracker
            // Runs in both modes so a mode change starts from a known polarity
            always @* begin
                have_mark_d = have_mark_q;
                last_pol_d = last_pol_q;
                viol = 1'b0;
                if (both_marks) begin
                    // Both slicers firing is no valid mark; polarity is kept
                    viol = 1'b1;
                end else if (pos_mark) begin
                    viol = have_mark_q & (last_pol_q == `QRXO_POL_POS);
                    have_mark_d = 1'b1;
                    last_pol_d = `QRXO_POL_POS;
                end else if (neg_mark) begin
                    viol = have_mark_q & (last_pol_q == `QRXO_POL_NEG);
                    have_mark_d = 1'b1;
                    last_pol_d = `QRXO_POL_NEG;
                end
            end

            always @(posedge clk_i) begin
                if (sys_rst_i) begin
                    have_mark_q <= `QRXO_RST_BIT;
                    last_pol_q <= `QRXO_POL_POS;
                end else if (rise) begin
                    have_mark_q <= have_mark_d;
                    last_pol_q <= last_pol_d;
                end
            end

            // ==========================================================
            // Rail selection
            always @* begin
                mute = mute_s & loss_bit;
                if (mute) begin
                    pos_d = 1'b0;
                    neg_d = 1'b0;
                end else if (single_s[ch]) begin
                    pos_d = nrz_bit;
                    neg_d = viol;
                end else begin
                    pos_d = plus_bit;
                    neg_d = minus_bit;
                end
            end

            // ==========================================================
            // Output registers, launched on the recovered clock rise only
            always @(posedge clk_i) begin
                if (sys_rst_i) begin
                    pos_q <= `QRXO_RST_BIT;
                    neg_q <= `QRXO_RST_BIT;
                end else if (rise) begin
                    pos_q <= pos_d;
                    neg_q <= neg_d;
                end
            end

            // ==========================================================
            // Loss indication
            // Updated on rises only, so a set flag stands a full period
            always @(posedge clk_i) begin
                if (sys_rst_i) begin
                    loss_q <= `QRXO_RST_BIT;
                end else if (rise) begin
                    loss_q <= loss_bit;
                end
            end

            // ==========================================================
            // Channel outputs
            assign rx_clk_o[ch] = clk_out_q;
            assign rx_pos_rail_out[ch] = pos_q;
            assign rx_neg_rail_out[ch] = neg_q;
            assign rx_loss_flag[ch] = loss_q;
        end
    endgenerate

endmodule

// ===== verif/qrxo_properties.sv
// Purpose: Port checks for qrxo_top
// Assumes: Inputs stable around each recovered clock rise
// Notes: Pin rise to output is 3 cycles
`timescale 1ns/1ps
module qrxo_properties #(parameter NUM_CHAN = 4) (
    input wire clk_i, // Clock
    input wire sys_rst_i, // Reset
    input wire [NUM_CHAN-1:0] rx_rclk_i, // Rclk in
    input wire [NUM_CHAN-1:0] rx_line_plus_in, // Plus
    input wire [NUM_CHAN-1:0] rx_line_minus_in, // Minus
    input wire [NUM_CHAN-1:0] rx_loss_det_i, // Loss in
    input wire [NUM_CHAN-1:0] single_rail_i, // Mode
    input wire rx_mute_on_loss_enable, // Mute
    input wire [NUM_CHAN-1:0] rx_clk_o, // Rclk out
    input wire [NUM_CHAN-1:0] rx_pos_rail_out, // Pos
    input wire [NUM_CHAN-1:0] rx_neg_rail_out, // Neg
    input wire [NUM_CHAN-1:0] rx_loss_flag // Loss
);
    // ========================================
    // Channel checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire m0 = rx_mute_on_loss_enable & rx_loss_det_i[0];
    wire m3 = rx_mute_on_loss_enable & rx_loss_det_i[3];
    sequence s_rise; $rose(rx_rclk_i[0]); endsequence
    sequence s_out; ##2 !rx_clk_o[0] ##1 rx_clk_o[0]; endsequence
    property p_clk; s_rise |-> s_out; endproperty
    a_clk: assert property (p_clk) else $error("clock out late");
    property p_clks; !$past(sys_rst_i, 3) |-> rx_clk_o == $past(rx_rclk_i, 3); endproperty
    a_clks: assert property (p_clks) else $error("channel clock out wrong");
    property p_pos; s_rise ##0 (!single_rail_i[0] && !m0)
        |-> ##3 rx_pos_rail_out[0] == $past(rx_line_plus_in[0], 3); endproperty
    a_pos: assert property (p_pos) else $error("dual pos wrong");
    property p_nrz; s_rise ##0 (single_rail_i[0] && !m0)
        |-> ##3 rx_pos_rail_out[0] == $past(rx_line_plus_in[0] | rx_line_minus_in[0], 3); endproperty
    a_nrz: assert property (p_nrz) else $error("nrz wrong");
    property p_loss; s_rise |-> ##3 rx_loss_flag[0] == $past(rx_loss_det_i[0], 3); endproperty
    a_loss: assert property (p_loss) else $error("loss wrong");
    property p_hold; !(rx_clk_o[0] && !$past(rx_clk_o[0]))
        |-> $stable({rx_pos_rail_out[0], rx_neg_rail_out[0], rx_loss_flag[0]}); endproperty
    a_hold: assert property (p_hold) else $error("output moved off edge");
    property p_viol; s_rise ##0 (single_rail_i[0] && rx_line_plus_in[0] && rx_line_minus_in[0] && !m0)
        |-> ##3 rx_neg_rail_out[0]; endproperty
    a_viol: assert property (p_viol) else $error("violation missed");
    property p_mute; s_rise ##0 m0 |-> ##3 !rx_pos_rail_out[0] && !rx_neg_rail_out[0]; endproperty
    a_mute: assert property (p_mute) else $error("mute failed");
    property p_ch3; $rose(rx_rclk_i[3]) ##0 (!single_rail_i[3] && !m3)
        |-> ##3 rx_neg_rail_out[3] == $past(rx_line_minus_in[3], 3); endproperty
    a_ch3: assert property (p_ch3) else $error("ch3 neg wrong");
endmodule

// ===== verif/qrxo_framer_model.sv
// Purpose: Framer model sampling receive outputs
// Assumes: Channel clocks run together
// Notes: Each sample toggles seen_o
`timescale 1ns/1ps
module qrxo_framer_model (
    input wire [3:0] rclk_i, // Recovered clocks
    input wire [3:0] pos_i, // Pos rails
    input wire [3:0] neg_i, // Neg rails
    input wire [3:0] loss_i, // Loss flags
    output reg [11:0] word_o, // Sample
    output reg seen_o // Toggles per sample
);
    // ========================================
    // Sampling
    initial seen_o = 1'b0;
    always @(negedge rclk_i[0]) begin
        word_o <= {loss_i, neg_i, pos_i};
        seen_o <= ~seen_o;
    end
endmodule

// ===== verif/testbench.sv
// Purpose: Self-checking bench for qrxo_top
// Assumes: All recovered clocks driven in phase
// Notes: Expectations queued per recovered clock rise
`timescale 1ns/1ps
module testbench;
    // ========================================
    // Stimulus and scoring
    reg clk_i = 1'b0, sys_rst_i = 1'b1, mute = 1'b0;
    reg [3:0] rclk = 4'h0, plus = 4'h0, minus = 4'h0, los = 4'h0, sr = 4'h0, pol = 4'h0, have = 4'h0;
    wire [3:0] clk_o, pos_o, neg_o, loss_o;
    wire [11:0] word;
    wire seen;
    reg [11:0] q[$];
    reg [11:0] e;
    reg [31:0] r;
    integer fails = 0, checked = 0, i;
    always #2.5 clk_i = ~clk_i;
    qrxo_top qrxo_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rx_rclk_i(rclk), .rx_line_plus_in(plus),
        .rx_line_minus_in(minus), .rx_loss_det_i(los), .single_rail_i(sr), .rx_mute_on_loss_enable(mute),
        .rx_clk_o(clk_o), .rx_pos_rail_out(pos_o), .rx_neg_rail_out(neg_o), .rx_loss_flag(loss_o));
    qrxo_framer_model qrxo_framer_model_inst (.rclk_i(clk_o), .pos_i(pos_o), .neg_i(neg_o), .loss_i(loss_o),
        .word_o(word), .seen_o(seen));
    task cmp(input [11:0] exp, input [11:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task results;
        begin
            $display("checked %0d fails %0d", checked, fails);
            if (fails == 0 && checked > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task beat(input [3:0] p, input [3:0] m, input [3:0] l, input [3:0] s, input mu);
        integer c;
        reg v;
        begin
            for (c = 0; c < 4; c = c + 1) begin
                v = (p[c] & m[c]) | ((p[c] ^ m[c]) & have[c] & (pol[c] == m[c]));
                if (p[c] ^ m[c]) begin
                    pol[c] = m[c];
                    have[c] = 1'b1;
                end
                e[c] = !(mu & l[c]) & (s[c] ? p[c] | m[c] : p[c]);
                e[c+4] = !(mu & l[c]) & (s[c] ? v : m[c]);
                e[c+8] = l[c];
            end
            q.push_back(e);
            @(posedge clk_i);
            {plus, minus, los, sr, mute, rclk} <= {p, m, l, s, mu, 4'h0};
            repeat (12) @(posedge clk_i);
            rclk <= 4'hf;
            repeat (12) @(posedge clk_i);
        end
    endtask
    initial begin
        wait (sys_rst_i == 1'b0);
        forever begin
            @(seen);
            cmp((q.size() > 0) ? q.pop_front() : 12'hxxx, word);
        end
    end
    initial begin
        #100000;
        fails = fails + 1;
        results;
    end
    initial begin
        r = $urandom(32'h98b9d374);
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        #1 cmp(12'h000, {loss_o, neg_o, pos_o});
        beat(4'hf, 4'h0, 4'h0, 4'hf, 1'b0);
        beat(4'hf, 4'h0, 4'h0, 4'hf, 1'b0);
        beat(4'h0, 4'h0, 4'h0, 4'hf, 1'b0);
        beat(4'h3, 4'hf, 4'h0, 4'h5, 1'b0);
        beat(4'h0, 4'h0, 4'hf, 4'h0, 1'b0);
        beat(4'hf, 4'hf, 4'ha, 4'h3, 1'b1);
        beat(4'h5, 4'ha, 4'h0, 4'h0, 1'b1);
        for (i = 0; i < 200; i = i + 1) begin
            r = $urandom;
            beat(r[3:0], r[7:4], r[11:8] & r[15:12], r[19:16], r[20]);
        end
        @(posedge clk_i);
        rclk <= 4'h0;
        repeat (20) @(posedge clk_i);
        cmp(12'h000, 12'(q.size()));
        results;
    end
endmodule
bind qrxo_top qrxo_properties #(.NUM_CHAN(NUM_CHAN)) qrxo_properties_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .rx_rclk_i(rx_rclk_i), .rx_line_plus_in(rx_line_plus_in), .rx_line_minus_in(rx_line_minus_in),
    .rx_loss_det_i(rx_loss_det_i), .single_rail_i(single_rail_i), .rx_mute_on_loss_enable(rx_mute_on_loss_enable),
    .rx_clk_o(rx_clk_o), .rx_pos_rail_out(rx_pos_rail_out), .rx_neg_rail_out(rx_neg_rail_out),
    .rx_loss_flag(rx_loss_flag));
